/* File: siu_pkg.sv */
// Package for the exception and low-power control unit.
// Assumes one clock domain (pclk) and an APB slave register port.
package siu_pkg;
    // Register byte offsets
    localparam logic [7:0] SIU_OFF_BWS = 8'h00; // break_wait_status
    localparam logic [7:0] SIU_OFF_RSS = 8'h04; // reset_source_status
    localparam logic [7:0] SIU_OFF_BFC = 8'h08; // break_flag_control
    localparam logic [7:0] SIU_OFF_CFG = 8'h0C; // configuration bits
    localparam logic [7:0] SIU_OFF_ST = 8'h10; // live state
    // Field positions
    localparam int SIU_BW_BIT = 1; // break_wait_flag
    localparam int SIU_BCE_BIT = 0; // break_clear_enable
    localparam int SIU_CFG_SSR = 0; // short_stop_recovery
    localparam int SIU_CFG_WDD = 1; // watchdog_disable
    // Reset source bit positions
    localparam int SIU_RS_LVI = 1;
    localparam int SIU_RS_ADR = 2;
    localparam int SIU_RS_OPC = 3;
    localparam int SIU_RS_WDG = 4;
    localparam int SIU_RS_PIN = 6;
    localparam int SIU_RS_POR = 7;
    // Reset values
    localparam logic [7:0] SIU_RSS_RESET = 8'h80;
    localparam logic [1:0] SIU_CFG_RESET = 2'h0;
    // Recovery timing in crystal cycles
    localparam int SIU_REC_LONG = 4096;
    localparam int SIU_REC_SHORT = 32;
    // Controller states, Gray along run, stack, wait, stop, recover
    typedef enum logic [2:0] {
        SIU_RUN = 3'b000,
        SIU_STACK = 3'b001,
        SIU_WAIT = 3'b011,
        SIU_STOP = 3'b010,
        SIU_RECOV = 3'b110
    } siu_state_t;
endpackage

/* File: siu_ctrl.sv */
// Exception, break and low-power controller for a small 8-bit core.
// Assumes the core reports instruction boundaries and special opcodes as pclk
// pulses, xtal_tick marks crystal cycles, reset causes are pclk-domain levels.
//
// What this block does
// - Service interrupts only at instruction end
// - Enter when mask clear and source enabled
// - Highest priority pending source wins
// - Pending interrupt served before resuming code
// - Index high register never pushed
// - Software interrupt ignores mask bit
// - Software stacks PC, hardware PC minus one
// - Reset beats every interrupt, no arbitration
// - Break forces software-interrupt vector
// - Clearing during break needs enable bit
// - Two-step flags stay protected in break while enable bit clear
// - Wait or stop clears mask, stops core
// - Wait wakes on enabled interrupt, stack next
// - Break exits wait and sets wait flag
// - Watchdog runs in wait when enabled
// - Stop resets counter, gates both clocks
// - Stop exits on interrupt; stack after recovery
// - Recovery 4096 cycles, or 32 if short
// - Counter held until recovery begins
// - Break inactive in stop, state unchanged
// - Break-wait flag cleared by zero write, reset
// - Six source flags, clear on read
// - Each source flag marks last reset
// - Enable bit one allows break clearing
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module siu_ctrl #(
    parameter int NSRC = 8, // Hardware interrupt sources, bit 0 highest
    parameter int REC_LONG = siu_pkg::SIU_REC_LONG // Long recovery, shorten in sim
) (
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side
    input wire logic instr_end, // Pulse at instruction boundary
    input wire logic swi_exec, // Software interrupt opcode done
    input wire logic wait_exec, // Wait opcode done
    input wire logic stop_exec, // Stop opcode done
    input wire logic rti_exec, // Return-from-interrupt done
    input wire logic mask_bit, // Interrupt mask in condition codes
    input wire logic [NSRC-1:0] irq_pend, // Peripheral requests
    input wire logic [NSRC-1:0] irq_en, // Peripheral enables
    input wire logic break_req, // Break module request
    input wire logic xtal_tick, // One pulse per crystal cycle
    // Reset causes, levels held during reset
    input wire logic por_evt,
    input wire logic pin_rst,
    input wire logic wdg_rst,
    input wire logic opc_rst,
    input wire logic adr_rst,
    input wire logic lvi_rst,
    // Outputs to core and clocking
    output logic int_start, // Pulse: begin stacking
    output logic [3:0] int_vector, // Vector index, 0 = software/break
    output logic stack_pc_minus1, // Hardware entry stacks PC-1
    output logic stack_index_high, // Always low: index high not pushed
    output logic mask_clear, // Pulse: clear mask bit
    output logic cpu_clk_en,
    output logic base_clk_en,
    output logic xtal_clk_en,
    output logic break_active,
    output logic break_logic_en,
    output logic flag_clear_allow, // Other modules may clear flags
    output logic watchdog_run,
    output logic wdg_disable_cfg
);
    localparam int CW = 13;
    localparam logic [CW-1:0] LONG_N = CW'(REC_LONG - 1);
    localparam logic [CW-1:0] SHORT_N = CW'(siu_pkg::SIU_REC_SHORT - 1);

    // Priority encoder; lowest index is highest priority
    function automatic logic [3:0] pick(input logic [NSRC-1:0] r);
        pick = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (r[i])
            begin
                pick = 4'(i + 1);
            end
        end
    endfunction

    // All state in one record
    typedef struct packed {
        siu_pkg::siu_state_t st;
        logic [CW-1:0] cnt;
        logic [1:0] cfg;
        logic bce;
        logic bw;
        logic [7:0] rss;
        logic brk;
        logic [NSRC-1:0] req_s1;
        logic [NSRC-1:0] req_s2;
        logic brk_s1;
        logic brk_s2;
        logic rst_seen;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic int_start;
        logic [3:0] vec;
        logic pcm1;
        logic mclr;
    } siu_reg_t;

    siu_reg_t r;
    siu_reg_t next_r;
    logic [NSRC-1:0] live;
    logic [5:0] cause;
    logic rd_rss;
    logic acc;
    logic fin; // Access phase with pready seen high
    logic bw_set; // Break woke the core this cycle

    // Next-state logic
    always_comb
    begin
        next_r = r;
        next_r.int_start = 1'b0;
        next_r.mclr = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        // Pending requests pass two flops since peripherals may be async
        next_r.req_s1 = irq_pend & irq_en;
        next_r.req_s2 = r.req_s1;
        next_r.brk_s1 = break_req;
        next_r.brk_s2 = r.brk_s1;
        live = r.req_s2;
        cause = {por_evt, pin_rst, wdg_rst, opc_rst, adr_rst, lvi_rst};
        acc = psel && penable && !r.pready;
        fin = psel && penable && r.pready;
        bw_set = 1'b0;
        // Clear on read only once the master has taken the data
        rd_rss = fin && !pwrite && paddr == siu_pkg::SIU_OFF_RSS;
        // Reset causes latch once per reset episode
        next_r.rst_seen = |cause;
        if (|cause && !r.rst_seen)
        begin
            if (por_evt)
            begin
                next_r.rss = siu_pkg::SIU_RSS_RESET;
            end
            else
            begin
                next_r.rss[siu_pkg::SIU_RS_PIN] = r.rss[siu_pkg::SIU_RS_PIN] | pin_rst;
                next_r.rss[siu_pkg::SIU_RS_WDG] = r.rss[siu_pkg::SIU_RS_WDG] | wdg_rst;
                next_r.rss[siu_pkg::SIU_RS_OPC] = r.rss[siu_pkg::SIU_RS_OPC] | opc_rst;
                next_r.rss[siu_pkg::SIU_RS_ADR] = r.rss[siu_pkg::SIU_RS_ADR] | adr_rst;
                next_r.rss[siu_pkg::SIU_RS_LVI] = r.rss[siu_pkg::SIU_RS_LVI] | lvi_rst;
            end
        end
        else if (rd_rss)
        begin
            next_r.rss = 8'h00;
        end
        // Any reset cause aborts everything else
        if (|cause)
        begin
            next_r.st = siu_pkg::SIU_RUN;
            next_r.bw = 1'b0;
            next_r.brk = 1'b0;
            next_r.cnt = '0;
        end
        else
        begin
            case (r.st)
                siu_pkg::SIU_RUN:
                begin
                    // Decisions only at boundaries
                    if (instr_end)
                    begin
                        if (r.brk_s2)
                        begin
                            next_r.st = siu_pkg::SIU_STACK;
                            next_r.vec = 4'h0;
                            next_r.pcm1 = 1'b1;
                            next_r.brk = 1'b1;
                        end
                        else if (swi_exec)
                        begin
                            next_r.st = siu_pkg::SIU_STACK;
                            next_r.vec = 4'h0;
                            next_r.pcm1 = 1'b0;
                        end
                        else if (stop_exec)
                        begin
                            next_r.st = siu_pkg::SIU_STOP;
                            next_r.cnt = '0;
                            next_r.mclr = 1'b1;
                        end
                        else if (wait_exec)
                        begin
                            next_r.st = siu_pkg::SIU_WAIT;
                            next_r.mclr = 1'b1;
                        end
                        // After a return this boundary serves the next pending one
                        else if (!mask_bit && |live)
                        begin
                            next_r.st = siu_pkg::SIU_STACK;
                            next_r.vec = pick(live);
                            next_r.pcm1 = 1'b1;
                        end
                    end
                    if (rti_exec)
                    begin
                        next_r.brk = 1'b0;
                    end
                end
                siu_pkg::SIU_STACK:
                begin
                    next_r.int_start = 1'b1;
                    next_r.st = siu_pkg::SIU_RUN;
                end
                siu_pkg::SIU_WAIT:
                begin
                    // Mask is cleared on entry, so any enabled request wakes
                    if (r.brk_s2)
                    begin
                        next_r.bw = 1'b1;
                        bw_set = 1'b1;
                        next_r.brk = 1'b1;
                        next_r.vec = 4'h0;
                        next_r.pcm1 = 1'b1;
                        next_r.st = siu_pkg::SIU_STACK;
                    end
                    else if (|live)
                    begin
                        next_r.vec = pick(live);
                        next_r.pcm1 = 1'b1;
                        next_r.st = siu_pkg::SIU_STACK;
                    end
                end
                siu_pkg::SIU_STOP:
                begin
                    next_r.cnt = '0;
                    if (|live)
                    begin
                        next_r.vec = pick(live);
                        next_r.pcm1 = 1'b1;
                        next_r.st = siu_pkg::SIU_RECOV;
                    end
                end
                siu_pkg::SIU_RECOV:
                begin
                    // Counts crystal cycles; choice sampled each cycle
                    if (xtal_tick)
                    begin
                        if (r.cnt >= (r.cfg[siu_pkg::SIU_CFG_SSR] ? SHORT_N : LONG_N))
                        begin
                            next_r.st = siu_pkg::SIU_STACK;
                            next_r.cnt = '0;
                        end
                        else
                        begin
                            next_r.cnt = r.cnt + 1'b1;
                        end
                    end
                end
                default:
                begin
                    next_r.st = siu_pkg::SIU_RUN;
                end
            endcase
        end
        // Register reads, one wait state
        if (acc)
        begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                siu_pkg::SIU_OFF_BWS:
                begin
                    next_r.prdata[siu_pkg::SIU_BW_BIT] = r.bw;
                end
                siu_pkg::SIU_OFF_RSS:
                begin
                    next_r.prdata[7:0] = r.rss;
                end
                siu_pkg::SIU_OFF_BFC:
                begin
                    next_r.prdata[siu_pkg::SIU_BCE_BIT] = r.bce;
                end
                siu_pkg::SIU_OFF_CFG:
                begin
                    next_r.prdata[1:0] = r.cfg;
                end
                siu_pkg::SIU_OFF_ST:
                begin
                    next_r.prdata[3:0] = {r.brk, r.st};
                end
                default:
                begin
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        // Writes land only at the edge where pready is seen high
        if (fin && pwrite)
        begin
            case (paddr)
                siu_pkg::SIU_OFF_BWS:
                begin
                    // Zero write clears; a break event in the same cycle wins
                    if (!pwdata[siu_pkg::SIU_BW_BIT] && !bw_set)
                    begin
                        next_r.bw = 1'b0;
                    end
                end
                siu_pkg::SIU_OFF_BFC:
                begin
                    next_r.bce = pwdata[siu_pkg::SIU_BCE_BIT];
                end
                siu_pkg::SIU_OFF_CFG:
                begin
                    next_r.cfg = pwdata[1:0];
                end
                default:
                begin
                    next_r.cfg = r.cfg;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.rss <= siu_pkg::SIU_RSS_RESET;
            r.cfg <= siu_pkg::SIU_CFG_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Outputs straight from flops, index high tied low
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign int_start = r.int_start;
    assign int_vector = r.vec;
    assign stack_pc_minus1 = r.pcm1;
    assign stack_index_high = 1'b0;
    assign mask_clear = r.mclr;
    // Core stopped in wait, stop and recovery
    assign cpu_clk_en = r.st == siu_pkg::SIU_RUN || r.st == siu_pkg::SIU_STACK;
    assign base_clk_en = r.st != siu_pkg::SIU_STOP && r.st != siu_pkg::SIU_RECOV;
    assign xtal_clk_en = r.st != siu_pkg::SIU_STOP;
    assign break_active = r.brk;
    // Recovery still counts as stop, so break stays off until stacking
    assign break_logic_en = r.st != siu_pkg::SIU_STOP && r.st != siu_pkg::SIU_RECOV;
    // Two-step flags rely on the same gate, so protection holds in break only while bce is 0
    assign flag_clear_allow = !r.brk || r.bce;
    assign watchdog_run = !r.cfg[siu_pkg::SIU_CFG_WDD] && r.st != siu_pkg::SIU_STOP;
    assign wdg_disable_cfg = r.cfg[siu_pkg::SIU_CFG_WDD];
endmodule // siu_ctrl
`default_nettype wire

/* File: siu_ctrl_monitor.sv */
// Port checker for the exception and low-power controller.
// Assumes it is bound to siu_ctrl; one clock pclk, reset presetn.
`timescale 1ns/1ns
`default_nettype none
module siu_ctrl_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic instr_end,
    input wire logic swi_exec,
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic mask_bit,
    input wire logic break_req,
    input wire logic por_evt,
    input wire logic pin_rst,
    input wire logic wdg_rst,
    input wire logic opc_rst,
    input wire logic adr_rst,
    input wire logic lvi_rst,
    input wire logic int_start,
    input wire logic [3:0] int_vector,
    input wire logic stack_pc_minus1,
    input wire logic stack_index_high,
    input wire logic mask_clear,
    input wire logic cpu_clk_en,
    input wire logic base_clk_en,
    input wire logic break_active,
    input wire logic break_logic_en,
    input wire logic watchdog_run,
    input wire logic wdg_disable_cfg
);
    // Any reset cause at all
    wire logic rc_any = por_evt | pin_rst | wdg_rst | opc_rst | adr_rst | lvi_rst;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Break is synced late, so it must be quiet a few cycles first
    sequence no_brk;
        !break_req [*3];
    endsequence
    idx_never_a: assert property (!stack_index_high) else $error("index high pushed");
    swi_entry_a: assert property (instr_end && swi_exec && !rc_any |-> ##2 int_start)
        else $error("software entry missing");
    swi_vec_a: assert property (no_brk ##0 (instr_end && swi_exec) |=> int_vector == 4'h0 && !stack_pc_minus1)
        else $error("software entry vector or stacking wrong");
    hw_pcm1_a: assert property (int_start && int_vector != 4'h0 |-> stack_pc_minus1)
        else $error("hardware entry must stack pc minus one");
    masked_a: assert property (no_brk ##0 (instr_end && mask_bit && !swi_exec && !rc_any) |-> ##2 !int_start)
        else $error("entry while masked");
    low_power_a: assert property (no_brk ##0 (instr_end && (wait_exec || stop_exec)) |=> mask_clear && !cpu_clk_en)
        else $error("low power entry wrong");
    stop_clk_a: assert property (no_brk ##0 (instr_end && stop_exec) |=> !base_clk_en)
        else $error("stop keeps clocks");
    brk_stop_a: assert property (!base_clk_en |-> !break_logic_en) else $error("break live in stop");
    rst_prio_a: assert property (rc_any ##1 rc_any |-> !int_start && cpu_clk_en)
        else $error("reset lost to interrupt");
    wdg_wait_a: assert property ($fell(cpu_clk_en) && base_clk_en && !wdg_disable_cfg |-> watchdog_run)
        else $error("watchdog stopped in wait");
    // Main scenarios reached
    cover property (int_start && stack_pc_minus1);
    cover property (break_active && !cpu_clk_en);
    cover property ($rose(base_clk_en));
endmodule // siu_ctrl_monitor
`default_nettype wire

/* File: siu_core_model.sv */
// Behavioural core and crystal beside the controller.
// Assumes the bench picks the opcode kind on op_sel.
`timescale 1ns/1ns
`default_nettype none
module siu_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cpu_clk_en,
    input wire logic int_start,
    input wire logic mask_clear,
    input wire logic unmask, // Bench pulse: software clears the mask
    input wire logic [2:0] op_sel,
    output logic instr_end,
    output logic swi_exec,
    output logic wait_exec,
    output logic stop_exec,
    output logic mask_bit,
    output logic xtal_tick
);
    logic [1:0] phase; // Cycle within a four-cycle instruction
    // Instruction phase, crystal tick and mask bit
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= 2'h0;
            xtal_tick <= 1'b0;
            mask_bit <= 1'b1;
        end
        else
        begin
            xtal_tick <= !xtal_tick; // Oscillator free runs at half rate
            if (cpu_clk_en)
                phase <= phase + 2'h1; // Frozen while unclocked
            if (int_start)
                mask_bit <= 1'b1; // Entry masks further requests
            else if (mask_clear || unmask)
                mask_bit <= 1'b0;
        end
    end
    // Opcodes end only with a whole instruction
    assign instr_end = cpu_clk_en && phase == 2'h3;
    assign swi_exec = instr_end && op_sel[0];
    assign wait_exec = instr_end && op_sel[1];
    assign stop_exec = instr_end && op_sel[2];
endmodule // siu_core_model
`default_nettype wire

/* File: test_siu_ctrl.sv */
// Self-checking bench for siu_ctrl.
// Assumes siu_pkg, siu_ctrl, siu_core_model and the monitor are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_siu_ctrl;
    localparam int REC = 64; // Shortened long recovery
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, break_req = 0;
    logic [7:0] paddr = 8'h00, irq_pend = 8'h00, irq_en = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [2:0] op_sel = 3'h0; // Opcode kind for the core model
    logic unmask = 0; // Software clears the mask in the core model
    logic [5:0] rc = 6'h00; // Reset causes, por down to lvi
    wire [31:0] prdata;
    wire [3:0] int_vector;
    wire pready, pslverr, instr_end, swi_exec, wait_exec, stop_exec, mask_bit, xtal_tick, int_start;
    wire mask_clear, cpu_clk_en, base_clk_en, xtal_clk_en, break_active, break_logic_en;
    wire flag_clear_allow, watchdog_run, wdg_disable_cfg, stack_pc_minus1, stack_index_high;
    int err_count = 0, n_compared = 0, n;
    int pos[6] = '{siu_pkg::SIU_RS_POR, siu_pkg::SIU_RS_PIN, siu_pkg::SIU_RS_WDG,
        siu_pkg::SIU_RS_OPC, siu_pkg::SIU_RS_ADR, siu_pkg::SIU_RS_LVI};
    siu_ctrl #(.REC_LONG(REC)) DUT (.*, .rti_exec(1'b0), .por_evt(rc[5]), .pin_rst(rc[4]),
        .wdg_rst(rc[3]), .opc_rst(rc[2]), .adr_rst(rc[1]), .lvi_rst(rc[0]));
    siu_core_model core (.*);
    // Free running 100 MHz clock
    always #5 pclk = ~pclk;
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        chk(32'(pslverr), 32'(a > siu_pkg::SIU_OFF_ST));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Core runs one opcode of the chosen kind
    task automatic issue(input logic [2:0] o);
        op_sel <= o;
        @(posedge pclk iff instr_end);
        op_sel <= 3'h0;
    endtask
    // Cycles until stacking starts, bounded
    task automatic wait_int();
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (int_start !== 1'b1 && n < 400);
    endtask
    // New requests settle while masked, then the mask opens
    task automatic hw(input logic [7:0] p, input logic [7:0] e, input logic [3:0] v);
        @(posedge pclk);
        irq_pend <= p;
        irq_en <= e;
        repeat (4) @(posedge pclk);
        unmask <= 1'b1;
        @(posedge pclk);
        unmask <= 1'b0;
        wait_int();
        chk(32'(int_vector), 32'(v));
        chk(32'(stack_pc_minus1), 32'h1);
    endtask
    // Hang guard, far beyond the expected run
    initial
    begin
        #100000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, siu_pkg::SIU_OFF_RSS, 0);
        chk(rd, 32'h80);
        apb(0, siu_pkg::SIU_OFF_RSS, 0);
        chk(rd, 32'h0);
        apb(0, 8'h20, 0); // Unmapped place answers with an error
        // Each reset cause leaves only its own flag
        for (int i = 0; i < 6; i++)
        begin
            rc <= 6'h20 >> i;
            repeat (3) @(posedge pclk);
            rc <= 6'h00;
            @(posedge pclk);
            apb(0, siu_pkg::SIU_OFF_RSS, 0);
            chk(rd, 32'h1 << pos[i]);
        end
        issue(3'b001);
        wait_int();
        chk(32'(int_vector), 32'h0);
        chk(32'(stack_pc_minus1), 32'h0);
        hw(8'h0C, 8'hFF, 4'h3);
        hw(8'h08, 8'hFF, 4'h4);
        hw(8'h06, 8'h04, 4'h3);
        irq_pend <= 8'h00;
        repeat (4) @(posedge pclk);
        // Break wakes the core from wait
        issue(3'b010);
        repeat (6) @(posedge pclk);
        chk(32'(cpu_clk_en), 32'h0);
        chk(32'(mask_bit), 32'h0);
        chk(32'(watchdog_run), 32'h1);
        break_req <= 1'b1;
        wait_int();
        chk(32'(n < 9), 32'h1);
        apb(0, siu_pkg::SIU_OFF_BWS, 0);
        chk(rd, 32'h1 << siu_pkg::SIU_BW_BIT);
        chk(32'(flag_clear_allow), 32'h0);
        apb(1, siu_pkg::SIU_OFF_BFC, 32'h1);
        chk(32'(flag_clear_allow), 32'h1);
        apb(1, siu_pkg::SIU_OFF_BWS, 0);
        apb(0, siu_pkg::SIU_OFF_BWS, 0);
        chk(rd, 32'h0);
        break_req <= 1'b0;
        repeat (6) @(posedge pclk);
        // Enabled request wakes the core from wait
        issue(3'b010);
        repeat (4) @(posedge pclk);
        irq_pend <= 8'h01;
        irq_en <= 8'hFF;
        wait_int();
        chk(32'(n inside {[2:8]}), 32'h1);
        chk(32'(int_vector), 32'h1);
        // Stop recovery, long then short
        for (int s = 0; s < 2; s++)
        begin
            irq_pend <= 8'h00;
            apb(1, siu_pkg::SIU_OFF_CFG, 32'(s));
            issue(3'b100);
            repeat (4) @(posedge pclk);
            chk(32'(xtal_clk_en), 32'h0);
            chk(32'(base_clk_en), 32'h0);
            chk(32'(break_logic_en), 32'h0);
            irq_pend <= 8'h01;
            wait_int();
            chk(32'(n inside {[2 * (s ? 32 : REC) : 2 * (s ? 32 : REC) + 12]}), 32'h1);
        end
        end_of_test();
    end
endmodule // test_siu_ctrl
bind siu_ctrl siu_ctrl_monitor mon (.*);
`default_nettype wire
